// >>> hdl/cipher_sync_cfg.svh
// timing counts, field positions and reset values for the portable-side cipher control
`ifndef CIPHER_SYNC_CFG_SVH
`define CIPHER_SYNC_CFG_SVH
`define REQ_REPEAT_MAX 3'h5
`define REQ_COUNT_RESET 3'h0
`define KS_SEG_BITS 10'h168
`define KS_FRAME_LAST 10'h2cf
`define KS_INDEX_RESET 10'h000
`define KS_TAIL_END 9'h028
`define KS_B0_END 9'h068
`define KS_B1_START 9'h078
`define KS_B1_END 9'h0b8
`define KS_B2_START 9'h0c8
`define KS_B2_END 9'h108
`define KS_B3_START 9'h118
`define KS_SINGLE_END 9'h158
`define IV_BASIC_PAD 7'h00
`define IV_ADV_PAD 3'h0
`define LBN_TOP 4'hf
`define FRAME_WRAP 4'hf
`define FRAME_RESET 4'h0
`define MULTIFRAME_RESET 24'h000000
`define IV_RESET 35'h000000000
`define KEY_RESET 64'h0000000000000000
`endif

// >>> hdl/cipher_sync_pkg.sv
// types shared by the portable-side cipher mode control
package cipher_sync_pkg;
  typedef enum logic [6:0] {
    st_clear = 7'h01,
    st_start_wait = 7'h02,
    st_start_grant = 7'h04,
    st_encrypt = 7'h08,
    st_stop_wait = 7'h10,
    st_stop_grant = 7'h20,
    st_spare = 7'h40
  } mode_state_t;
  typedef enum logic [2:0] {
    mt_none = 3'h0,
    mt_start_request = 3'h1,
    mt_start_confirm = 3'h2,
    mt_start_grant = 3'h3,
    mt_stop_request = 3'h4,
    mt_stop_confirm = 3'h5,
    mt_stop_grant = 3'h6,
    mt_start_reject = 3'h7
  } mt_code_t;
  typedef enum logic [1:0] {
    bf_unprotected = 2'h0,
    bf_single = 2'h1,
    bf_multi = 2'h2
  } b_format_t;
  typedef struct packed {
    logic valid;
    mt_code_t code;
  } mt_msg_t;
  typedef struct packed {
    logic valid;
    logic ks;
    logic data;
  } ks_in_t;
  typedef struct packed {
    logic valid;
    logic data;
    logic downlink;
    logic applied;
  } cipher_out_t;
endpackage

// >>> hdl/frame_counter.sv
// shared frame and multiframe numbering, loadable for alignment with the partner
`timescale 1ns/1ps
`include "cipher_sync_cfg.svh"
module frame_counter #(
  parameter int MF_W = 24
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic frame_tick,
  input wire logic sync_load,
  input wire logic [3:0] sync_frame,
  input wire logic [MF_W-1:0] sync_multiframe,
  output logic [3:0] frame_number,
  output logic [MF_W-1:0] multiframe_number
);
  wire frame_wrap = (frame_number == `FRAME_WRAP);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      frame_number <= `FRAME_RESET;
      multiframe_number <= '0;
    end
    else if (sync_load)
    begin
      frame_number <= sync_frame; // RULE_22
      multiframe_number <= sync_multiframe;
    end
    else if (frame_tick)
    begin
      frame_number <= frame_number + 4'h1;
      if (frame_wrap)
        multiframe_number <= multiframe_number + {{(MF_W-1){1'b0}}, 1'b1}; // RULE_27
    end
  end
endmodule

// >>> hdl/ks_bit_mapper.sv
// decides which keystream segment bits cipher a field bit
`timescale 1ns/1ps
`include "cipher_sync_cfg.svh"
module ks_bit_mapper
  import cipher_sync_pkg::*;
(
  input wire logic [8:0] seg_index,
  input wire logic tail_control,
  input wire cipher_sync_pkg::b_format_t b_format,
  output logic used
);
  function automatic logic in_span(input logic [8:0] i, input logic [8:0] lo, input logic [8:0] hi);
    in_span = (i >= lo) && (i < hi);
  endfunction

  // tail bits only when the tail carries control data
  wire tail_part = (seg_index < `KS_TAIL_END) & tail_control; // RULE_24
  // crc spans of protected formats fall in the gaps and stay clear
  wire multi_part = in_span(seg_index, `KS_TAIL_END, `KS_B0_END)
    | in_span(seg_index, `KS_B1_START, `KS_B1_END)
    | in_span(seg_index, `KS_B2_START, `KS_B2_END)
    | in_span(seg_index, `KS_B3_START, `KS_SINGLE_END); // RULE_25
  wire single_part = in_span(seg_index, `KS_TAIL_END, `KS_SINGLE_END);
  wire unprot_part = (seg_index >= `KS_TAIL_END);

  assign used = tail_part
    | ((b_format == bf_unprotected) & unprot_part)
    | ((b_format == bf_single) & single_part)
    | ((b_format == bf_multi) & multi_part);
endmodule

// >>> hdl/cipher_mode_control.sv
// portable-side over-the-air cipher mode control, init value forming and keystream steering
`timescale 1ns/1ps
`include "cipher_sync_cfg.svh"
// Notes on behaviour
// RULE_01 - both ends begin clear, switch at frames
// RULE_02 - cipher key is 64 bits, bit 0 lsb
// RULE_03 - basic init value: frame, multiframe, zeros
// RULE_04 - advanced adds fifteen minus bearer number
// RULE_05 - reload generator every encrypted frame
// RULE_06 - 720 bits per frame, two halves
// RULE_07 - first half downlink, second half uplink
// RULE_08 - duplex encrypt ciphers both directions
// RULE_09 - switch messages clear, on duplex bearer; only the opening request checks duplex_bearer, repeats and grants do not
// RULE_10 - portable even frames, fixed odd frames
// RULE_11 - only portable side starts mode changes
// RULE_12 - mode covers all bearers, new ones inherit
// RULE_13 - start request next even, five tries
// RULE_14 - confirm reported, else disconnect indicated
// RULE_15 - decrypt from confirm, discard while waiting
// RULE_16 - grant next even, encrypt from grant
// RULE_17 - fixed side confirms in odd frames
// RULE_18 - fixed side disconnects without grant
// RULE_19 - fixed side decrypts from grant frame
// RULE_20 - reject only with default key index
// RULE_21 - stop request, confirm, grant back to clear
// RULE_22 - frame counters aligned on both sides
// RULE_23 - each segment is 360 generator bits
// RULE_24 - tail bits ciphered only for control tails
// RULE_25 - header and check bits never ciphered
// RULE_26 - decrypt uses the same xor mapping
// RULE_27 - multiframe advances on frame wrap
module cipher_mode_control
  import cipher_sync_pkg::*;
#(
  parameter int MF_W = 24
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic frame_tick,
  input wire logic sync_load,
  input wire logic [3:0] sync_frame,
  input wire logic [MF_W-1:0] sync_multiframe,
  input wire logic advanced_conn,
  input wire logic [3:0] logical_bearer_number,
  input wire logic duplex_bearer,
  input wire logic [63:0] cipher_key,
  input wire logic cipher_switch_request,
  input wire cipher_sync_pkg::mt_msg_t rx_msg,
  input wire cipher_sync_pkg::ks_in_t ks_in,
  input wire logic tail_control,
  input wire cipher_sync_pkg::b_format_t b_format,
  output cipher_sync_pkg::mt_msg_t tx_msg,
  output logic ksg_load,
  output logic [63:0] ksg_key,
  output logic [34:0] ksg_init_value,
  output logic cipher_switch_confirmation,
  output logic disconnect_indication,
  output logic rx_discard,
  output logic tx_encrypt,
  output logic rx_encrypt,
  output cipher_sync_pkg::cipher_out_t cipher_out
);
  import cipher_sync_pkg::*;

  mode_state_t state;
  logic [3:0] frame_number;
  logic [MF_W-1:0] multiframe_number;
  logic frame_go;
  logic pending;
  logic [2:0] req_count;
  logic [9:0] ks_index;
  logic ks_active;
  logic bit_used;

  frame_counter #(
    .MF_W(MF_W)
  ) u_frame_counter (
    .core_clk(core_clk),
    .reset(reset),
    .frame_tick(frame_tick),
    .sync_load(sync_load),
    .sync_frame(sync_frame),
    .sync_multiframe(sync_multiframe),
    .frame_number(frame_number),
    .multiframe_number(multiframe_number)
  );

  // frame numbering has settled one cycle after the tick
  wire even_frame = ~frame_number[0];
  wire go_even = frame_go & even_frame; // RULE_10
  wire rx_cipher_start_confirm = rx_msg.valid & (rx_msg.code == mt_start_confirm);
  wire rx_cipher_stop_confirm = rx_msg.valid & (rx_msg.code == mt_stop_confirm);
  wire retry_left = (req_count < `REQ_REPEAT_MAX);
  // only this side opens a switch; the bearer must be duplex
  wire begin_switch = go_even & pending & duplex_bearer; // RULE_11 RULE_09
  wire grant_now = go_even & (state == st_start_grant);

  // init value layout
  wire [23:0] mf_field = multiframe_number[23:0];
  wire [3:0] lbn_star = `LBN_TOP - logical_bearer_number; // RULE_04
  wire [34:0] iv_basic = {`IV_BASIC_PAD, mf_field, frame_number}; // RULE_03
  wire [34:0] iv_advanced = {`IV_ADV_PAD, lbn_star, mf_field, frame_number}; // RULE_04
  wire [34:0] iv_now = advanced_conn ? iv_advanced : iv_basic;
  // load speculatively while waiting, so the confirm frame can already be decrypted
  wire need_ks = tx_encrypt | rx_encrypt | grant_now | (state == st_start_wait); // RULE_05

  // keystream position
  wire ks_take = ks_in.valid & ks_active;
  wire uplink_seg = (ks_index >= `KS_SEG_BITS); // RULE_23
  wire [9:0] seg_index_w = uplink_seg ? (ks_index - `KS_SEG_BITS) : ks_index;
  // downlink segment is received here, uplink segment is sent
  wire seg_mode = uplink_seg ? tx_encrypt : rx_encrypt; // RULE_07 RULE_08
  wire apply = bit_used & seg_mode;

  ks_bit_mapper u_ks_bit_mapper (
    .seg_index(seg_index_w[8:0]),
    .tail_control(tail_control),
    .b_format(b_format),
    .used(bit_used)
  );

  always_ff @(posedge core_clk)
  begin
    if (reset)
      frame_go <= 1'b0;
    else
      frame_go <= frame_tick;
  end

  // a request in the consuming cycle survives
  always_ff @(posedge core_clk)
  begin
    if (reset)
      pending <= 1'b0;
    else
      pending <= cipher_switch_request | (pending & ~begin_switch);
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state <= st_clear; // RULE_01
      req_count <= `REQ_COUNT_RESET;
      tx_msg <= '{valid: 1'b0, code: mt_none};
      tx_encrypt <= 1'b0;
      rx_encrypt <= 1'b0;
      rx_discard <= 1'b0;
      cipher_switch_confirmation <= 1'b0;
      disconnect_indication <= 1'b0;
    end
    else
    begin
      cipher_switch_confirmation <= 1'b0;
      disconnect_indication <= 1'b0;
      if (frame_go)
        tx_msg <= '{valid: 1'b0, code: mt_none};
      case (state)
        st_clear:
          if (begin_switch)
          begin
            tx_msg <= '{valid: 1'b1, code: mt_start_request}; // RULE_13
            req_count <= 3'h1;
            rx_discard <= 1'b1; // RULE_15
            state <= st_start_wait;
          end
        st_start_wait:
          if (rx_cipher_start_confirm)
          begin
            // confirm wins over a coinciding frame edge
            cipher_switch_confirmation <= 1'b1; // RULE_14
            rx_encrypt <= 1'b1; // RULE_15
            rx_discard <= 1'b0;
            state <= st_start_grant;
          end
          else if (go_even && retry_left)
          begin
            tx_msg <= '{valid: 1'b1, code: mt_start_request}; // RULE_13
            req_count <= req_count + 3'h1;
          end
          else if (go_even)
          begin
            disconnect_indication <= 1'b1; // RULE_14
            rx_discard <= 1'b0;
            state <= st_clear;
          end
        st_start_grant:
          if (go_even)
          begin
            tx_msg <= '{valid: 1'b1, code: mt_start_grant}; // RULE_16
            tx_encrypt <= 1'b1; // RULE_16 RULE_12
            state <= st_encrypt;
          end
        st_encrypt:
          if (begin_switch)
          begin
            tx_msg <= '{valid: 1'b1, code: mt_stop_request}; // RULE_21
            req_count <= 3'h1;
            rx_discard <= 1'b1;
            state <= st_stop_wait;
          end
        st_stop_wait:
          if (rx_cipher_stop_confirm)
          begin
            cipher_switch_confirmation <= 1'b1; // RULE_21
            rx_encrypt <= 1'b0;
            rx_discard <= 1'b0;
            state <= st_stop_grant;
          end
          else if (go_even && retry_left)
          begin
            tx_msg <= '{valid: 1'b1, code: mt_stop_request}; // RULE_21
            req_count <= req_count + 3'h1;
          end
          else if (go_even)
          begin
            // connection released, so nothing stays ciphered
            disconnect_indication <= 1'b1;
            rx_discard <= 1'b0;
            tx_encrypt <= 1'b0;
            rx_encrypt <= 1'b0;
            state <= st_clear;
          end
        st_stop_grant:
          if (go_even)
          begin
            tx_msg <= '{valid: 1'b1, code: mt_stop_grant}; // RULE_21
            tx_encrypt <= 1'b0;
            state <= st_clear;
          end
        default:
          state <= st_clear;
      endcase
    end
  end

  // generator reload per encrypted frame
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ksg_load <= 1'b0;
      ksg_key <= `KEY_RESET;
      ksg_init_value <= `IV_RESET;
    end
    else
    begin
      ksg_load <= frame_go & need_ks; // RULE_05
      if (frame_go & need_ks)
      begin
        ksg_key <= cipher_key; // RULE_02
        ksg_init_value <= iv_now; // RULE_03 RULE_04
      end
    end
  end

  // 720 keystream bits per frame, then idle until the next reload
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ks_index <= `KS_INDEX_RESET;
      ks_active <= 1'b0;
    end
    else if (frame_go)
    begin
      ks_index <= `KS_INDEX_RESET;
      ks_active <= need_ks;
    end
    else if (ks_take)
    begin
      ks_index <= ks_index + 10'h001;
      if (ks_index == `KS_FRAME_LAST)
        ks_active <= 1'b0; // RULE_06
    end
  end

  // same xor both ways; unused positions pass the data through
  always_ff @(posedge core_clk)
  begin
    if (reset)
      cipher_out <= '0;
    else
    begin
      cipher_out.valid <= ks_take;
      cipher_out.data <= ks_in.data ^ (ks_in.ks & apply); // RULE_26
      cipher_out.downlink <= ~uplink_seg; // RULE_07
      cipher_out.applied <= apply & ks_take;
    end
  end

  sequence start_sent_s;
    go_even && state == st_clear && pending && duplex_bearer;
  endsequence

  sequence out_of_tries_s;
    go_even && state == st_start_wait && !rx_cipher_start_confirm && req_count == `REQ_REPEAT_MAX;
  endsequence

  start_first_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_13
    start_sent_s |=> tx_msg.valid && tx_msg.code == mt_start_request && state == st_start_wait)
    else $error("start request not sent in the even frame");
  req_limit_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_13
    req_count <= `REQ_REPEAT_MAX)
    else $error("request repeated more than five times");
  timeout_drop_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_14
    out_of_tries_s |=> disconnect_indication && state == st_clear ##1 !disconnect_indication)
    else $error("missing single disconnect after last request");
  confirm_report_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_15
    state == st_start_wait && rx_cipher_start_confirm |=> cipher_switch_confirmation && rx_encrypt && !rx_discard)
    else $error("start confirm not reported or decrypt not begun");
  tx_even_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_10
    $rose(tx_msg.valid) |-> !frame_number[0])
    else $error("message raised outside an even frame");
  grant_encrypt_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_16
    grant_now |=> tx_msg.code == mt_start_grant && tx_encrypt && ksg_load)
    else $error("grant frame not encrypted");
  iv_layout_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_03
    frame_go && need_ks |=> ksg_init_value[3:0] == $past(frame_number) && ksg_init_value[34:32] == 3'h0)
    else $error("init value layout wrong");
  frame_end_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_06
    ks_take && ks_index == `KS_FRAME_LAST && !frame_go |=> !ks_active)
    else $error("keystream ran past 720 bits");
  clear_pass_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_25
    ks_take && !apply |=> cipher_out.data == $past(ks_in.data) && !cipher_out.applied)
    else $error("unused position was ciphered");
  start_clear_a: assert property (@(posedge core_clk) // RULE_01
    $fell(reset) |-> state == st_clear && !tx_encrypt && !rx_encrypt)
    else $error("not clear after reset");
endmodule

// >>> sim/fixed_side_model.sv
// fixed-side partner that answers mode switch requests in odd frames
`timescale 1ns/1ps
module fixed_side_model
  import cipher_sync_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic frame_tick,
  input wire logic sync_load,
  input wire logic [3:0] sync_frame,
  input wire logic silent,
  input wire cipher_sync_pkg::mt_msg_t tx_msg,
  output cipher_sync_pkg::mt_msg_t rx_msg
);
  logic [3:0] frame;
  logic [2:0] left;
  logic [2:0] idle;
  logic seen;
  mt_code_t answer;
  always @(posedge core_clk)
  begin
    seen <= tx_msg.valid;
    // idle code wanders so a stale code is never read as a message
    rx_msg <= '{valid: 1'b0, code: mt_code_t'(idle)};
    if (reset)
    begin
      frame <= 4'h0;
      left <= 3'h0;
      idle <= 3'h0;
    end
    else
    begin
      idle <= idle + 3'h1;
      if (sync_load)
        frame <= sync_frame;
      else if (frame_tick)
      begin
        frame <= frame + 4'h1;
        if (!frame[0] && left != 3'h0)
        begin
          rx_msg <= '{valid: 1'b1, code: answer};
          left <= left - 3'h1;
        end
      end
      if (tx_msg.valid && !seen && !silent)
      begin
        if (tx_msg.code == mt_start_grant || tx_msg.code == mt_stop_grant)
          left <= 3'h0;
        else if (left == 3'h0 && (tx_msg.code == mt_start_request || tx_msg.code == mt_stop_request))
        begin
          // never rejects: no default key index in use
          answer <= (tx_msg.code == mt_start_request) ? mt_start_confirm : mt_stop_confirm;
          left <= 3'h6;
        end
      end
    end
  end
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the portable-side cipher mode control
`timescale 1ns/1ps
module tb_top;
  import cipher_sync_pkg::*;
  localparam int FR = 800;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic frame_tick = 1'b0;
  logic sync_load = 1'b0;
  logic [3:0] sync_frame = 4'hd;
  logic [23:0] sync_multiframe = 24'h000000;
  logic advanced_conn = 1'b0;
  logic [3:0] logical_bearer_number = 4'h0;
  logic [63:0] cipher_key = 64'h0;
  logic cipher_switch_request = 1'b0;
  logic tail_control = 1'b0;
  logic silent = 1'b0;
  logic duplex_bearer = 1'b1;
  ks_in_t ks_in = '0;
  b_format_t b_format = bf_unprotected;
  mt_msg_t rx_msg;
  mt_msg_t tx_msg;
  cipher_out_t cipher_out;
  logic ksg_load, conf, disc, rx_discard, tx_encrypt, rx_encrypt;
  logic tx_seen = 1'b0;
  logic [63:0] ksg_key;
  logic [34:0] ksg_init_value;
  logic [34:0] exp_iv;
  logic [3:0] fn;
  logic [23:0] mf;
  int miscompares = 0;
  int total_checks = 0;
  int conf_count = 0;
  int disc_count = 0;
  int load_count = 0;
  int seed = 32'ha2d1f011;
  mt_code_t qtx[$];
  cipher_out_t qco[$];

  cipher_mode_control #(.MF_W(24)) i_cipher_mode_control (.core_clk(core_clk), .reset(reset),
    .frame_tick(frame_tick), .sync_load(sync_load), .sync_frame(sync_frame),
    .sync_multiframe(sync_multiframe), .advanced_conn(advanced_conn),
    .logical_bearer_number(logical_bearer_number), .duplex_bearer(duplex_bearer), .cipher_key(cipher_key),
    .cipher_switch_request(cipher_switch_request), .rx_msg(rx_msg), .ks_in(ks_in),
    .tail_control(tail_control), .b_format(b_format), .tx_msg(tx_msg), .ksg_load(ksg_load),
    .ksg_key(ksg_key), .ksg_init_value(ksg_init_value), .cipher_switch_confirmation(conf),
    .disconnect_indication(disc), .rx_discard(rx_discard), .tx_encrypt(tx_encrypt),
    .rx_encrypt(rx_encrypt), .cipher_out(cipher_out));

  fixed_side_model i_fixed_side_model (.core_clk(core_clk), .reset(reset), .frame_tick(frame_tick),
    .sync_load(sync_load), .sync_frame(sync_frame), .silent(silent), .tx_msg(tx_msg), .rx_msg(rx_msg));

  always #5 core_clk = ~core_clk;

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic request(input mt_code_t a, input mt_code_t b, input int n);
    cipher_switch_request = 1'b1;
    repeat (n) qtx.push_back(a);
    if (b != mt_none)
      qtx.push_back(b);
    step(1);
    cipher_switch_request = 1'b0;
  endtask

  // one frame; optionally streams the full 720 keystream bits
  task automatic frame(input logic strm, input b_format_t bf);
    int s;
    logic u, k, d;
    frame_tick = 1'b1;
    mf = (fn == 4'hf) ? mf + 24'h1 : mf;
    fn = fn + 4'h1;
    exp_iv = advanced_conn ? {3'h0, 4'hf - logical_bearer_number, mf, fn} : {7'h00, mf, fn};
    step(1);
    frame_tick = 1'b0;
    b_format = bf;
    tail_control = 1'($random(seed));
    step(3);
    for (int i = 0; i < 720 && strm; i++)
    begin
      s = (i < 360) ? i : i - 360;
      u = (s < 40) ? tail_control : (bf == bf_unprotected) || (s < 344 && (bf == bf_single || (s - 40) % 80 < 64));
      k = 1'($random(seed));
      d = 1'($random(seed));
      ks_in = '{valid: 1'b1, ks: k, data: d};
      qco.push_back('{valid: 1'b1, data: d ^ (k & u), downlink: i < 360, applied: u});
      step(1);
    end
    ks_in = '0;
    step(strm ? FR - 724 : FR - 4);
  endtask

  always @(posedge core_clk)
  begin
    tx_seen <= tx_msg.valid;
    if (!reset)
    begin
      if (ksg_load)
      begin
        check("init_value", 64'(ksg_init_value), 64'(exp_iv));
        check("key", ksg_key, cipher_key);
      end
      if (tx_msg.valid && !tx_seen)
        check("tx_msg", 64'(tx_msg.code), (qtx.size() > 0) ? 64'(qtx.pop_front()) : 64'hx);
      if (cipher_out.valid)
        check("cipher_out", 64'(cipher_out), (qco.size() > 0) ? 64'(qco.pop_front()) : 64'hx);
      conf_count += int'(conf);
      disc_count += int'(disc);
      load_count += int'(ksg_load);
    end
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    end_sim;
  end

  initial
  begin
    cipher_key = {$random(seed), $random(seed)};
    sync_multiframe = 24'($random(seed));
    step(4);
    reset = 1'b0;
    sync_load = 1'b1;
    fn = sync_frame;
    mf = sync_multiframe;
    step(1);
    sync_load = 1'b0;
    step(3);
    request(mt_start_request, mt_start_grant, 1);
    frame(1'b0, bf_unprotected);
    check("rx_discard", 64'(rx_discard), 64'h1);
    check("rx_encrypt", 64'(rx_encrypt), 64'h0);
    frame(1'b0, bf_unprotected);
    check("rx_encrypt", 64'(rx_encrypt), 64'h1);
    check("tx_encrypt", 64'(tx_encrypt), 64'h0);
    frame(1'b0, bf_unprotected);
    check("tx_encrypt", 64'(tx_encrypt), 64'h1);
    // frame number wrapped here, so the multiframe field moved on
    for (int j = 0; j < 3; j++)
    begin
      advanced_conn = j[0];
      logical_bearer_number = 4'($random(seed));
      frame(1'b1, b_format_t'(j));
    end
    request(mt_stop_request, mt_stop_grant, 1);
    frame(1'b0, bf_unprotected);
    frame(1'b0, bf_unprotected);
    check("rx_encrypt", 64'(rx_encrypt), 64'h0);
    frame(1'b0, bf_unprotected);
    check("tx_encrypt", 64'(tx_encrypt), 64'h0);
    silent = 1'b1;
    // simplex bearer: the request must wait for a duplex one
    duplex_bearer = 1'b0;
    request(mt_start_request, mt_none, 5);
    repeat (2) frame(1'b0, bf_multi);
    check("rx_discard", 64'(rx_discard), 64'h0);
    duplex_bearer = 1'b1;
    repeat (12) frame(1'b0, bf_multi);
    check("confirmations", 64'(conf_count), 64'h2);
    check("disconnects", 64'(disc_count), 64'h1);
    check("tx_encrypt", 64'(tx_encrypt), 64'h0);
    // two start, three loop, three stop frames, ten while waiting unanswered
    check("reloads", 64'(load_count), 64'h12);
    check("tx_left", 64'(qtx.size()), 64'h0);
    check("ks_left", 64'(qco.size()), 64'h0);
    end_sim;
  end
endmodule
